// ==== src/pds_pkg.sv ====
package pds_pkg;

    // Width of one sample word on the serial link.
    localparam int WORD_BITS = 16;

    // Number of words the buffer memory between shifter and latch can hold; its head register holds one more.
    localparam int FIFO_DEPTH = 16;

    // Input latch value after reset: all zeros is half scale, zero output.
    localparam logic [15:0] LATCH_RESET = 16'h0000;

    // Shift register value after reset.
    localparam logic [15:0] SHIFT_RESET = 16'h0000;

    // System clock rate in hertz.
    localparam int CLK_HZ = 40_000_000;

    // Fastest data clock the serial input must follow, in hertz.
    localparam int LINK_CLK_MAX_HZ = 10_000_000;

    // System clock samples per fastest data clock period.
    localparam int SAMPLES_PER_LINK_CLK = CLK_HZ / LINK_CLK_MAX_HZ;

    // Reset value of the synchronisers for data clock and serial data.
    localparam logic [1:0] SYNC_LOW_RESET = 2'h0;

    // Reset value of the strobe synchroniser: the strobe idles high.
    localparam logic [1:0] SYNC_HIGH_RESET = 2'h3;

    // Bit counter value after reset and after each latch strobe.
    localparam logic [4:0] BIT_CNT_RESET = 5'h00;

    // Bit count at which a whole word has been shifted in.
    localparam logic [4:0] BIT_CNT_FULL = 5'h10;

    // Progress of word assembly since the last latch strobe.
    typedef enum logic [1:0] {
        PDS_EMPTY,
        PDS_PARTIAL,
        PDS_FULL
    } pds_asm_t;

endpackage

// ==== src/pds_word_if.sv ====
`timescale 1ns/100ps
// Carries whole sample words with a valid and ready handshake.
interface pds_word_if #(
    parameter int WIDTH = 16
);
    // Word offered by the source.
    logic [WIDTH-1:0] data;
    // Source has a word on data.
    logic valid;
    // Sink takes the word in this cycle when valid is high too.
    logic ready;

    // Side that offers words.
    modport src (
        output data,
        output valid,
        input ready
    );

    // Side that takes words.
    modport snk (
        input data,
        input valid,
        output ready
    );
endinterface

// ==== src/pds_fifo.sv ====
`timescale 1ns/100ps
// Word buffer with a registered head word, holding DEPTH words in its
// memory plus one in the output register. DEPTH must be a power of two.
module pds_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    pds_word_if.snk wr,
    pds_word_if.src rd
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    // Storage for words waiting behind the head register.
    logic [WIDTH-1:0] mem [DEPTH];
    // Write and read positions in the storage.
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    // Words held in the storage.
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    // Head word register and its valid flag.
    logic [WIDTH-1:0] head_reg;
    logic head_valid_reg;

    // Handshake decode.
    wire mem_empty = (cnt_reg == '0);
    wire push = wr.valid && wr.ready;
    wire load = !mem_empty && (!head_valid_reg || rd.ready);

    // Full refuses new words; the shifter is not held back, so the word is lost and flagged as an overrun.
    assign wr.ready = (cnt_reg != DEPTH_C);
    assign rd.valid = head_valid_reg;
    assign rd.data = head_reg;

    // Occupancy moves by one per push and one per head load.
    assign cnt_next = cnt_reg + CW'(push) - CW'(load);

    // The storage array is written only on an accepted push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr.data;
        end
    end

    // Pointers and occupancy.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(load);
            cnt_reg <= cnt_next;
        end
    end

    // Head register refills from storage or empties when taken.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            head_valid_reg <= 1'b0;
            head_reg <= '0;
        end else if (load) begin
            head_valid_reg <= 1'b1;
            head_reg <= mem[rd_ptr_reg];
        end else if (rd.ready) begin
            head_valid_reg <= 1'b0;
        end
    end
endmodule

// ==== src/pds_serial_port.sv ====
`timescale 1ns/100ps
module pds_serial_port #(
    parameter int WORD_BITS = pds_pkg::WORD_BITS,
    parameter int FIFO_DEPTH = pds_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic word_latch_strobe_n,
    input wire logic conv_ready,
    output logic [WORD_BITS-1:0] conv_word,
    output logic conv_load,
    output logic short_word,
    output logic overrun
);
    // Two-stage synchronisers; only the second stage feeds logic.
    logic [1:0] clk_sync_reg;
    logic [1:0] data_sync_reg;
    logic [1:0] strobe_sync_reg;
    // Previous synchronised levels for edge detection.
    logic clk_prev_reg;
    logic strobe_prev_reg;
    // Serial-to-parallel register, kept apart from the input latch.
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] shift_next;
    // Bits received since the last strobe, saturating at a whole word.
    logic [4:0] bit_cnt_reg;
    logic [4:0] bit_cnt_next;
    // Word assembly progress.
    pds_pkg::pds_asm_t asm_reg;
    pds_pkg::pds_asm_t asm_next;

    // Input latch that drives the converter core.
    logic [WORD_BITS-1:0] latch_reg;
    // One-cycle flag raised in the cycle a new latch word appears.
    logic load_reg;
    // One-cycle flag for a strobe that came before a whole word.
    logic short_reg;
    logic short_next;
    // One-cycle flag for a whole word that the full buffer refused.
    logic overrun_reg;
    logic overrun_next;

    // Whole words travel from the shifter into the buffer.
    pds_word_if #(.WIDTH(WORD_BITS)) push_if ();
    // Buffered words travel from the buffer to the input latch.
    pds_word_if #(.WIDTH(WORD_BITS)) pop_if ();

    // Second synchroniser stages, the only levels that logic reads.
    wire ser_clk_s = clk_sync_reg[1];
    // Synchronised serial data, delayed exactly like the data clock.
    wire ser_data_s = data_sync_reg[1];
    // Synchronised strobe, active low.
    wire strobe_s_n = strobe_sync_reg[1];

    // A data clock rise is a low-to-high step of the synchronised level.
    wire clk_rise = ser_clk_s && !clk_prev_reg;
    // A latch strobe is a high-to-low step of the synchronised level.
    wire strobe_fall = !strobe_s_n && strobe_prev_reg;
    // The sixteenth rise of a word completes it.
    wire last_rise = clk_rise
        && (bit_cnt_reg == pds_pkg::BIT_CNT_FULL - 5'h01);
    // All bits of the word are in the shift register.
    wire word_whole = (asm_reg == pds_pkg::PDS_FULL);
    // A strobe after a whole word hands that word on.
    wire word_done = strobe_fall && word_whole;
    // The latch takes a buffered word whenever the converter is ready.
    wire latch_take = pop_if.valid && conv_ready;

    // Each rise moves the word one place up and puts the new bit at the
    // bottom, so the first bit sent ends as the most significant bit.
    assign shift_next = clk_rise
        ? {shift_reg[WORD_BITS-2:0], ser_data_s}
        : shift_reg;

    // The count restarts at every strobe and stops at a whole word, so
    // extra rises keep only the last sixteen bits.
    assign bit_cnt_next = strobe_fall ? pds_pkg::BIT_CNT_RESET
        : (clk_rise && !word_whole) ? bit_cnt_reg + 5'h01
        : bit_cnt_reg;

    // A strobe before the sixteenth bit latches nothing and is flagged.
    assign short_next = strobe_fall && !word_whole;
    // A whole word that finds the buffer full is lost and is flagged.
    assign overrun_next = word_done && !push_if.ready;

    // The shifter offers its word to the buffer for one cycle.
    assign push_if.data = shift_reg;
    assign push_if.valid = word_done;
    // The buffer releases a word only when the converter can take it.
    assign pop_if.ready = conv_ready;

    // The latch and the flags leave the block straight from flip-flops.
    assign conv_word = latch_reg;
    assign conv_load = load_reg;
    assign short_word = short_reg;
    assign overrun = overrun_reg;

    // Assembly state: empty after a strobe, partial while bits arrive,
    // full once sixteen rises have been seen. A strobe always restarts.
    always_comb begin
        asm_next = asm_reg;
        case (asm_reg)
            pds_pkg::PDS_EMPTY: begin
                // The first rise of a word starts assembly.
                if (clk_rise && !strobe_fall) begin
                    asm_next = pds_pkg::PDS_PARTIAL;
                end
            end
            pds_pkg::PDS_PARTIAL: begin
                // A strobe here cuts the word short.
                if (strobe_fall) begin
                    asm_next = pds_pkg::PDS_EMPTY;
                end else if (last_rise) begin
                    asm_next = pds_pkg::PDS_FULL;
                end
            end
            pds_pkg::PDS_FULL: begin
                // The strobe hands the word on and starts the next one.
                if (strobe_fall) begin
                    asm_next = pds_pkg::PDS_EMPTY;
                end
            end
            default: begin
                // An unknown code falls back to a clean start.
                asm_next = pds_pkg::PDS_EMPTY;
            end
        endcase
    end

    // Two flip-flops per pin keep a metastable level away from logic;
    // four samples per data clock period follow the fastest link rate.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_sync_reg <= pds_pkg::SYNC_LOW_RESET;
            data_sync_reg <= pds_pkg::SYNC_LOW_RESET;
            strobe_sync_reg <= pds_pkg::SYNC_HIGH_RESET;
        end else begin
            clk_sync_reg <= {clk_sync_reg[0], ser_clk};
            data_sync_reg <= {data_sync_reg[0], ser_data};
            strobe_sync_reg <= {strobe_sync_reg[0], word_latch_strobe_n};
        end
    end

    // Previous levels for edge detection. They reset to the idle levels
    // of the pins so that no false edge follows reset.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_prev_reg <= 1'b0;
            strobe_prev_reg <= 1'b1;
        end else begin
            clk_prev_reg <= ser_clk_s;
            strobe_prev_reg <= strobe_s_n;
        end
    end

    // Serial-to-parallel register and its bit count.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            shift_reg <= WORD_BITS'(pds_pkg::SHIFT_RESET);
            bit_cnt_reg <= pds_pkg::BIT_CNT_RESET;
        end else begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Assembly state register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            asm_reg <= pds_pkg::PDS_EMPTY;
        end else begin
            asm_reg <= asm_next;
        end
    end

    // Status flags, each high for one cycle per event.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            short_reg <= 1'b0;
            overrun_reg <= 1'b0;
        end else begin
            short_reg <= short_next;
            overrun_reg <= overrun_next;
        end
    end

    // The buffer lets the sender run ahead of a converter that is busy,
    // so oversampled word rates do not depend on converter timing.
    pds_fifo #(
        .WIDTH(WORD_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .wr(push_if),
        .rd(pop_if)
    );

    // Input latch: it changes only on a taken word and otherwise keeps
    // its value whatever the link does. The reset word is half scale.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_reg <= WORD_BITS'(pds_pkg::LATCH_RESET);
            load_reg <= 1'b0;
        end else begin
            if (latch_take) begin
                latch_reg <= pop_if.data;
            end
            load_reg <= latch_take;
        end
    end
endmodule

// ==== verif/pds_serial_port_properties.sv ====
`timescale 1ns/100ps
// Watches the converter side of the serial port.
module pds_serial_port_properties #(
    parameter int WORD_BITS = 16,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic conv_ready,
    input wire logic [WORD_BITS-1:0] conv_word,
    input wire logic conv_load,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic word_latch_strobe_n,
    input wire logic short_word,
    input wire logic overrun
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // The latched word moves only around a load.
    AST_LATCH_HOLD: assert property ($changed(conv_word) |->
        conv_load || $past(conv_load)) else $error("word moved unloaded");
    // A load is only handed on while the converter is ready.
    AST_LOAD_READY: assert property (conv_load |->
        conv_ready || $past(conv_ready)) else $error("load while busy");
    // The strobe pin was low three cycles before a flag is raised.
    sequence strobe_seen_low;
        !$past(word_latch_strobe_n, 3);
    endsequence
    // A cut word is flagged only after a strobe.
    AST_SHORT_AFTER_STROBE: assert property (short_word |->
        strobe_seen_low) else $error("short flag without strobe");
    // A refused word is flagged only after a strobe.
    AST_OVERRUN_AFTER_STROBE: assert property (overrun |->
        strobe_seen_low) else $error("overrun flag without strobe");
    // The cut word flag lasts one cycle.
    AST_SHORT_PULSE: assert property (short_word |=>
        !short_word) else $error("short flag too long");
    // A cut word is never pushed, so it cannot overrun.
    AST_FLAGS_APART: assert property (!(short_word && overrun))
        else $error("short and overrun together");
    // Without a ready converter in the cycle before, no load appears.
    AST_NO_LOAD_UNREADY: assert property (!$past(conv_ready) |->
        !conv_load) else $error("load without ready");
endmodule
bind pds_serial_port pds_serial_port_properties #(.WORD_BITS(WORD_BITS),
    .FIFO_DEPTH(FIFO_DEPTH)) u_props (.*);

// ==== verif/pds_sender_model.sv ====
`timescale 1ns/100ps
// Upstream filter: shifts words out and pulses the strobe low.
module pds_sender_model (
    input wire logic clk,
    output logic ser_clk,
    output logic ser_data,
    output logic word_latch_strobe_n
);
    // The link idles with its clock low and the strobe high.
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        word_latch_strobe_n = 1'b1;
    end
    // Sends one word at 200 ns a bit, then one strobe pulse.
    task automatic send(input logic [15:0] w, input int nbits = 16);
        for (int i = 15; i >= 16 - nbits; i--) begin
            ser_data = w[i];
            repeat (4) @(negedge clk);
            ser_clk = 1'b1;
            repeat (4) @(negedge clk);
            ser_clk = 1'b0;
        end
        ser_data = ~w[0];
        word_latch_strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        word_latch_strobe_n = 1'b1;
    endtask
endmodule

// ==== verif/pds_serial_port_tb_top.sv ====
`timescale 1ns/100ps
// Sends words over the link and checks what the converter gets.
module pds_serial_port_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, conv_ready = 1'b0, conv_load;
    logic ser_clk, ser_data, word_latch_strobe_n;
    logic [15:0] conv_word;
    logic short_word, overrun;
    int short_seen = 0;
    int over_seen = 0;
    logic [15:0] vals [4] = '{16'h8000, 16'h7fff, 16'hffff, 16'h0001};
    int err_total = 0;
    int n_checks = 0;
    pds_serial_port DUT (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk),
        .ser_data(ser_data), .word_latch_strobe_n(word_latch_strobe_n),
        .conv_ready(conv_ready), .conv_word(conv_word),
        .conv_load(conv_load), .short_word(short_word),
        .overrun(overrun));
    pds_sender_model snd (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
        .word_latch_strobe_n(word_latch_strobe_n));
    // The system clock runs at 40 MHz.
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Counts the one-cycle status flags.
    always @(posedge clk) begin
        if (short_word === 1'b1) short_seen++;
        if (overrun === 1'b1) over_seen++;
    end
    // Compares one value and counts it.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Waits for the next load and compares the word it carries.
    task automatic take(input logic [15:0] exp);
        int n = 0;
        while (conv_load !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check(conv_word, exp);
        @(negedge clk);
    endtask
    // Buffers four words, checks the latch holds, then drains in order.
    task automatic test_burst();
        foreach (vals[i]) snd.send(vals[i]);
        check(conv_word, 16'h0000);
        conv_ready = 1'b1;
        foreach (vals[i]) take(vals[i]);
        conv_ready = 1'b0;
    endtask
    // Link traffic alone must not disturb the latched word.
    task automatic test_hold();
        snd.send(16'ha5c3);
        check(conv_word, 16'h0001);
        conv_ready = 1'b1;
        take(16'ha5c3);
    endtask
    // A strobe after eight bits is flagged and latches nothing.
    task automatic test_short();
        snd.send(16'h1234, 8);
        repeat (4) @(negedge clk);
        check(16'(short_seen), 16'h0001);
        check(conv_word, 16'ha5c3);
        snd.send(16'h5a5a);
        take(16'h5a5a);
    endtask
    // Eighteen words into a stalled converter: the last one is refused.
    task automatic test_overrun();
        conv_ready = 1'b0;
        for (int i = 0; i < 18; i++) snd.send(16'h0100 + 16'(i));
        repeat (4) @(negedge clk);
        check(16'(over_seen), 16'h0001);
        conv_ready = 1'b1;
        for (int i = 0; i < 17; i++) take(16'h0100 + 16'(i));
        repeat (8) @(negedge clk);
        check(conv_word, 16'h0110);
        check(16'(short_seen), 16'h0001);
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Main sequence after a 16-cycle reset.
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        test_burst();
        test_hold();
        test_short();
        test_overrun();
        stop_test();
    end
    // Cuts a hang short well past the expected run time.
    initial begin
        #400_000;
        err_total++;
        stop_test();
    end
endmodule
